/* rtl/pse_port_command_registers.sv */
`timescale 1ns/10ps
//
// Operation
// - irq gate low holds interrupt output inactive
// - gate bit never touches event registers
// - access bit selects 16-bit single or 8-bit dual
// - shutdown bit selects 3-bit or 1-bit priority
// - class flag only on change when enabled
// - detect flag only on change when enabled
// - restart register bits trigger class/detect per port
// - manual runs one cycle; semiauto sets enable
// - restart register reads back zero
// - restart during cool-down delayed until end
// - power register ignored in off mode
// - unconditional turn-on in listed cases
// - checked turn-on needs valid results and timing
// - timing miss reruns detection once, then gives up
// - semiauto keeps cycling while port off
// - power-off wins over power-on same write
// - faults and cool-down override power-on
// - turn-off clears port flags, status, enables
// - state change sets change flags, updates status
module pse_port_command_registers
    import pse_cmd_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_wr_en,
    input  wire logic        i_rd_en,
    input  wire logic [7:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire op_mode_t    i_mode,
    input  wire logic        i_turn_on_timing_check,
    input  wire logic        i_irq_pending,
    input  wire logic [3:0]  i_cooldown,
    input  wire logic [3:0]  i_fault_off,
    input  wire logic [3:0]  i_power_good,
    input  wire logic [3:0]  i_det_done,
    input  wire logic [3:0]  i_det_valid,
    input  wire logic [3:0]  i_det_changed,
    input  wire logic [3:0]  i_cls_done,
    input  wire logic [3:0]  i_cls_valid,
    input  wire logic [3:0]  i_cls_changed,
    input  wire logic [3:0]  i_turn_on_window_ok,
    output logic [7:0]       o_rdata,
    output logic             o_irq,
    output logic             o_wide_access,
    output logic             o_multi_level_shutdown,
    output logic [7:0]       o_priority_reg_a,
    output logic [3:0]       o_detect_enable_flag,
    output logic [3:0]       o_class_enable_flag,
    output logic [3:0]       o_start_detection,
    output logic [3:0]       o_start_classify,
    output logic [3:0]       o_port_power_on,
    output logic [3:0]       o_power_enabled_status,
    output logic [3:0]       o_power_good_status,
    output logic [3:0]       o_detection_event_flag,
    output logic [3:0]       o_class_event_flag,
    output logic [3:0]       o_power_enable_change_flag,
    output logic [3:0]       o_power_good_change_flag,
    output logic [3:0]       o_port_clear
);
    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] gen_cfg_ff;
    logic [3:0] det_en_ff;
    logic [3:0] cls_en_ff;
    logic [3:0] pon_ff;
    logic [3:0] retry_ff;
    logic [3:0] retry_cls_ff;
    logic [3:0] det_evt_ff;
    logic [3:0] cls_evt_ff;
    logic [3:0] pec_ff;
    logic [3:0] pgc_ff;
    logic [3:0] pg_ff;
    logic [3:0] clr_ff;
    logic [3:0] nxt_pon;
    logic [3:0] restart_det;
    logic [3:0] restart_cls;
    logic [3:0] pwr_on_req;
    logic [3:0] pwr_off_req;
    logic [3:0] turn_off;
    logic [3:0] direct_on;
    logic [3:0] checked_on;
    logic [3:0] retry_on;
    logic       wr_restart;
    logic       wr_power;
    pse_port_ctl_if ctl();

    // address match for one command code
    function automatic logic hit(input logic [7:0] a, input logic [7:0] code);
        hit = (a == code);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // write strobes, one-shot triggers
    assign wr_restart  = i_wr_en && hit(i_addr, ADDR_RESTART);
    assign wr_power    = i_wr_en && hit(i_addr, ADDR_POWER) && (i_mode != MODE_OFF);
    assign restart_det = wr_restart ? i_wdata[3:0] : 4'h0;
    assign restart_cls = wr_restart ? i_wdata[7:HI_NIBBLE] : 4'h0;
    assign pwr_off_req = wr_power ? i_wdata[7:HI_NIBBLE] : 4'h0;
    assign pwr_on_req  = (wr_power ? i_wdata[3:0] : 4'h0) & ~pwr_off_req;

    ////////////////////////////////////////////////////////////////////////////
    // configuration register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gen_cfg_ff <= GEN_CFG_RESET;
        end else if (i_wr_en && hit(i_addr, ADDR_GEN_CFG)) begin
            gen_cfg_ff <= i_wdata & GEN_CFG_WMASK;
        end
    end

    // read data; write-only triggers read zero
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 8'h00;
        end else if (i_rd_en) begin
            if (hit(i_addr, ADDR_GEN_CFG)) begin
                o_rdata <= gen_cfg_ff;
            end else begin
                o_rdata <= 8'h00;
            end
        end
    end

    // interrupt output gated by config; events untouched
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= i_irq_pending & gen_cfg_ff[BIT_IRQ_GATE];
        end
    end

    // mode selects exported to serial engine and shutdown logic
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_wide_access          <= 1'b0;
            o_multi_level_shutdown <= 1'b0;
            o_priority_reg_a       <= PRIO_REG_1BIT;
        end else begin
            o_wide_access          <= gen_cfg_ff[BIT_ACCESS_WIDTH];
            o_multi_level_shutdown <= gen_cfg_ff[BIT_MULTI_SHUTDOWN];
            o_priority_reg_a       <= gen_cfg_ff[BIT_MULTI_SHUTDOWN] ? PRIO_REG_3BIT_A : PRIO_REG_1BIT;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // restart handling; manual runs a cycle, semiauto sets enables
    assign ctl.det_req  = (i_mode == MODE_MANUAL) ? restart_det : 4'h0;
    assign ctl.cls_req  = (i_mode == MODE_MANUAL) ? restart_cls : 4'h0;
    assign ctl.cooldown = i_cooldown;

    restart_pending u_pend (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .ctl     (ctl)
    );

    // detect/class enables
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            det_en_ff <= 4'h0;
            cls_en_ff <= 4'h0;
        end else begin
            if (i_mode == MODE_SEMIAUTO) begin
                det_en_ff <= (det_en_ff & ~turn_off) | restart_det;
                cls_en_ff <= (cls_en_ff & ~turn_off) | restart_cls;
            end else begin
                det_en_ff <= det_en_ff & ~turn_off;
                cls_en_ff <= cls_en_ff & ~turn_off;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power-on decision per port
    assign turn_off   = pwr_off_req & pon_ff;
    assign direct_on  = pwr_on_req & ~i_cooldown & ~i_fault_off
                        & {4{(i_mode == MODE_MANUAL) || !i_turn_on_timing_check}}
                        | pwr_on_req & ~i_cooldown & ~i_fault_off
                        & {4{i_mode == MODE_SEMIAUTO}} & ~det_en_ff;
    assign checked_on = pwr_on_req & ~i_cooldown & ~i_fault_off & det_en_ff
                        & {4{(i_mode == MODE_SEMIAUTO) && i_turn_on_timing_check}}
                        & i_det_valid & (i_cls_valid | ~cls_en_ff) & i_turn_on_window_ok;
    // retry turns on only after its fresh result, inside the window
    assign retry_on   = ((retry_ff & i_det_done & i_det_valid & ~cls_en_ff)
                        | (retry_cls_ff & i_cls_done & i_cls_valid))
                        & i_turn_on_window_ok & ~i_cooldown & ~i_fault_off;

    // port power state; off and faults win
    always_comb begin
        nxt_pon = pon_ff | direct_on | checked_on | retry_on;
        nxt_pon = nxt_pon & ~pwr_off_req & ~i_fault_off;
    end

    // one retry per request when timing window missed
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            retry_ff     <= 4'h0;
            retry_cls_ff <= 4'h0;
        end else begin
            retry_ff     <= (retry_ff & ~i_det_done & ~(i_cls_done & retry_cls_ff) & ~pwr_off_req)
                            | (pwr_on_req & det_en_ff & ~i_turn_on_window_ok & ~i_cooldown
                            & {4{(i_mode == MODE_SEMIAUTO) && i_turn_on_timing_check}});
            retry_cls_ff <= (retry_cls_ff & ~i_cls_done) | (retry_ff & i_det_done & i_det_valid & cls_en_ff);
        end
    end

    // start pulses; semiauto cycles continuously while port off
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_start_detection <= 4'h0;
            o_start_classify  <= 4'h0;
        end else begin
            o_start_detection <= ctl.det_start
                                 | ({4{i_mode == MODE_SEMIAUTO}} & det_en_ff & ~pon_ff & ~i_cooldown)
                                 | (pwr_on_req & det_en_ff & ~i_turn_on_window_ok & ~i_cooldown);
            o_start_classify  <= ctl.cls_start
                                 | ({4{i_mode == MODE_SEMIAUTO}} & cls_en_ff & ~pon_ff & i_det_done & i_det_valid);
        end
    end

    // power status and change events
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pon_ff <= 4'h0;
            pg_ff  <= 4'h0;
            pec_ff <= 4'h0;
            pgc_ff <= 4'h0;
        end else begin
            pon_ff <= nxt_pon;
            pg_ff  <= i_power_good & nxt_pon;
            pec_ff <= nxt_pon ^ pon_ff;
            pgc_ff <= (i_power_good & nxt_pon) ^ pg_ff;
        end
    end

    // detection/class event flags, set wins over clear
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            det_evt_ff <= 4'h0;
            cls_evt_ff <= 4'h0;
            clr_ff     <= 4'h0;
        end else begin
            det_evt_ff <= (det_evt_ff & ~turn_off)
                          | (i_det_done & (i_det_changed | {4{!gen_cfg_ff[BIT_DETECT_CHANGE]}}));
            cls_evt_ff <= (cls_evt_ff & ~turn_off)
                          | (i_cls_done & (i_cls_changed | {4{!gen_cfg_ff[BIT_CLASS_CHANGE]}}));
            clr_ff     <= turn_off;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered outputs
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_detect_enable_flag       <= 4'h0;
            o_class_enable_flag        <= 4'h0;
            o_port_power_on            <= 4'h0;
            o_power_enabled_status     <= 4'h0;
            o_power_good_status        <= 4'h0;
            o_detection_event_flag     <= 4'h0;
            o_class_event_flag         <= 4'h0;
            o_power_enable_change_flag <= 4'h0;
            o_power_good_change_flag   <= 4'h0;
            o_port_clear               <= 4'h0;
        end else begin
            o_detect_enable_flag       <= det_en_ff;
            o_class_enable_flag        <= cls_en_ff;
            o_port_power_on            <= pon_ff;
            o_power_enabled_status     <= pon_ff;
            o_power_good_status        <= pg_ff;
            o_detection_event_flag     <= det_evt_ff;
            o_class_event_flag         <= cls_evt_ff;
            o_power_enable_change_flag <= pec_ff;
            o_power_good_change_flag   <= pgc_ff;
            o_port_clear               <= clr_ff;
        end
    end
endmodule

/* rtl/pse_cmd_pkg.sv */
package pse_cmd_pkg;
    localparam int          NUM_PORTS          = 4;
    localparam logic [7:0]  ADDR_GEN_CFG       = 8'h17;
    localparam logic [7:0]  ADDR_RESTART       = 8'h18;
    localparam logic [7:0]  ADDR_POWER         = 8'h19;
    localparam logic [7:0]  GEN_CFG_RESET      = 8'h80;
    localparam logic [7:0]  GEN_CFG_WMASK      = 8'hfc;
    localparam int          BIT_IRQ_GATE       = 7;
    localparam int          BIT_ACCESS_WIDTH   = 5;
    localparam int          BIT_MULTI_SHUTDOWN = 4;
    localparam int          BIT_CLASS_CHANGE   = 3;
    localparam int          BIT_DETECT_CHANGE  = 2;
    localparam int          HI_NIBBLE          = 4;
    localparam logic [7:0]  PRIO_REG_1BIT      = 8'h15;
    localparam logic [7:0]  PRIO_REG_3BIT_A    = 8'h27;
    localparam logic [7:0]  PRIO_REG_3BIT_B    = 8'h28;
    localparam int          OSS_IDLE_US        = 200;
    localparam int          CLK_MHZ            = 100;
    localparam int          OSS_IDLE_CYCLES    = OSS_IDLE_US * CLK_MHZ;
    typedef enum logic [1:0] {MODE_OFF, MODE_MANUAL, MODE_SEMIAUTO} op_mode_t;
endpackage

/* rtl/pse_port_ctl_if.sv */
`timescale 1ns/10ps
interface pse_port_ctl_if;
    logic [3:0] det_req;
    logic [3:0] cls_req;
    logic [3:0] cooldown;
    logic [3:0] det_start;
    logic [3:0] cls_start;
    modport owner (output det_req, output cls_req, output cooldown, input det_start, input cls_start);
    modport holder (input det_req, input cls_req, input cooldown, output det_start, output cls_start);
endinterface

/* rtl/restart_pending.sv */
`timescale 1ns/10ps
// holds restart requests through a port cool-down, issues one start pulse after
module restart_pending
    import pse_cmd_pkg::*;
(
    input  wire logic  i_clk,
    input  wire logic  i_rst_n,
    pse_port_ctl_if.holder ctl
);
    logic [3:0] det_pend_ff;
    logic [3:0] cls_pend_ff;
    logic [3:0] det_start_ff;
    logic [3:0] cls_start_ff;

    // accept during cool-down, fire once when it ends
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            det_pend_ff  <= 4'h0;
            cls_pend_ff  <= 4'h0;
            det_start_ff <= 4'h0;
            cls_start_ff <= 4'h0;
        end else begin
            det_start_ff <= (det_pend_ff | ctl.det_req) & ~ctl.cooldown;
            cls_start_ff <= (cls_pend_ff | ctl.cls_req) & ~ctl.cooldown;
            det_pend_ff  <= (det_pend_ff | ctl.det_req) & ctl.cooldown;
            cls_pend_ff  <= (cls_pend_ff | ctl.cls_req) & ctl.cooldown;
        end
    end

    assign ctl.det_start = det_start_ff;
    assign ctl.cls_start = cls_start_ff;
endmodule

/* testbench/pse_cmd_monitor.sv */
`timescale 1ns/10ps
module pse_cmd_monitor
    import pse_cmd_pkg::*;
(
    input wire logic       i_clk,
    input wire logic       i_rst_n,
    input wire logic       i_wr_en,
    input wire logic       i_rd_en,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire op_mode_t   i_mode,
    input wire logic       i_irq_pending,
    input wire logic [3:0] i_cooldown,
    input wire logic [3:0] i_fault_off,
    input wire logic [7:0] o_rdata,
    input wire logic       o_irq,
    input wire logic       o_wide_access,
    input wire logic       o_multi_level_shutdown,
    input wire logic [3:0] o_port_power_on,
    input wire logic [3:0] o_power_enable_change_flag
);
    logic [7:0] cfg_ff;
    logic       wr_pwr;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    ////////////////////////////////////////////////////////////
    // shadow of the configuration register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n)
            cfg_ff <= GEN_CFG_RESET;
        else if (i_wr_en && i_addr == ADDR_GEN_CFG)
            cfg_ff <= i_wdata & GEN_CFG_WMASK;
    end
    assign wr_pwr = i_wr_en && i_addr == ADDR_POWER;
    ////////////////////////////////////////////////////////////
    property p_rd_zero;
        i_rd_en && i_addr != ADDR_GEN_CFG |=> o_rdata == 8'h00;
    endproperty
    property p_irq_gate;
        !(cfg_ff[BIT_IRQ_GATE] && i_irq_pending) |=> !o_irq;
    endproperty
    property p_cfg_copy;
        {o_wide_access, o_multi_level_shutdown} == $past(cfg_ff[5:4]);
    endproperty
    property p_off_mode;
        wr_pwr && i_mode == MODE_OFF |-> ##2 o_power_enable_change_flag == 4'h0;
    endproperty
    property p_off_wins;
        logic [7:0] d;
        (wr_pwr && i_mode != MODE_OFF, d = i_wdata) |-> ##2 (o_port_power_on & d[7:4]) == 4'h0;
    endproperty
    property p_manual_on;
        logic [7:0] d;
        (wr_pwr && i_mode == MODE_MANUAL && i_cooldown == 4'h0 && i_fault_off == 4'h0, d = i_wdata)
            |-> ##2 (o_port_power_on & d[3:0] & ~d[7:4]) == (d[3:0] & ~d[7:4]);
    endproperty
    property p_cool_hold;
        (o_port_power_on & ~$past(o_port_power_on) & $past(i_cooldown, 1) & $past(i_cooldown, 2)
            & $past(i_cooldown, 3)) == 4'h0;
    endproperty
    property p_change_flag;
        |o_power_enable_change_flag |->
            (o_power_enable_change_flag & ~(o_port_power_on ^ $past(o_port_power_on))) == 4'h0;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("read of trigger or unmapped not zero");
    a_irq_gate: assert property (p_irq_gate) else $error("irq active while gated");
    a_cfg_copy: assert property (p_cfg_copy) else $error("access or priority select wrong");
    a_off_mode: assert property (p_off_mode) else $error("power write acted in off mode");
    a_off_wins: assert property (p_off_wins) else $error("port on after off request");
    a_manual_on: assert property (p_manual_on) else $error("manual power on missing");
    a_cool_hold: assert property (p_cool_hold) else $error("port on during cool-down");
    a_change_flag: assert property (p_change_flag) else $error("change flag without change");
    c_on: cover property ($rose(o_port_power_on[0]));
    c_irq: cover property (o_irq);
    c_rd: cover property (i_rd_en && i_addr == ADDR_RESTART);
endmodule

/* testbench/pse_host_model.sv */
`timescale 1ns/10ps
module pse_host_model
    import pse_cmd_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic [7:0] i_rdata,
    output logic            o_wr_en = 1'b0,
    output logic            o_rd_en = 1'b0,
    output logic [7:0]      o_addr  = 8'h00,
    output logic [7:0]      o_wdata = 8'h00
);
    logic [7:0] cfg_seen = GEN_CFG_RESET;
    // one transfer, then enables drop low and address/data lines show the inverse of their last value
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_wr_en <= w;
        o_rd_en <= !w;
        o_addr  <= a;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr_en <= 1'b0;
        o_rd_en <= 1'b0;
        o_addr  <= ~a;
        o_wdata <= ~d;
    endtask
    // shutdown input idles before multi-level priority is switched on
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (a == ADDR_GEN_CFG && d[BIT_MULTI_SHUTDOWN] && !cfg_seen[BIT_MULTI_SHUTDOWN])
            repeat (OSS_IDLE_CYCLES) @(posedge i_clk);
        if (a == ADDR_GEN_CFG)
            cfg_seen = d;
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        xfer(1'b0, a, 8'h00);
        @(posedge i_clk);
        #1 d = i_rdata;
    endtask
endmodule

/* testbench/pse_port_command_registers_test.sv */
`timescale 1ns/10ps
module pse_port_command_registers_test;
    import pse_cmd_pkg::*;
    logic       i_clk = 1'b0, i_rst_n = 1'b0, i_turn_on_timing_check = 1'b0, i_irq_pending = 1'b0;
    logic       i_wr_en, i_rd_en, o_irq, o_wide_access, o_multi_level_shutdown;
    logic [7:0] i_addr, i_wdata, o_rdata, o_priority_reg_a, r;
    op_mode_t   i_mode = MODE_MANUAL;
    logic [3:0] i_cooldown = 4'h0, i_fault_off = 4'h0, i_power_good = 4'h0, i_det_done = 4'h0;
    logic [3:0] i_det_valid = 4'h0, i_det_changed = 4'h0, i_cls_done = 4'h0, i_cls_valid = 4'h0;
    logic [3:0] i_cls_changed = 4'h0, i_turn_on_window_ok = 4'h0;
    logic [3:0] o_detect_enable_flag, o_class_enable_flag, o_start_detection, o_start_classify;
    logic [3:0] o_port_power_on, o_power_enabled_status, o_power_good_status, o_detection_event_flag;
    logic [3:0] o_class_event_flag, o_power_enable_change_flag, o_power_good_change_flag, o_port_clear;
    logic [7:0] ra[3] = '{ADDR_RESTART, ADDR_POWER, 8'h55};
    int         fails = 0, comparisons = 0, cyc = 0, m_cfg, m_on, n, k, ndet, ncls;
    always #5 i_clk = ~i_clk;
    pse_host_model i_host (.i_clk, .i_rdata(o_rdata), .o_wr_en(i_wr_en), .o_rd_en(i_rd_en),
        .o_addr(i_addr), .o_wdata(i_wdata));
    pse_port_command_registers i_dut (.i_clk, .i_rst_n, .i_wr_en, .i_rd_en, .i_addr, .i_wdata, .i_mode,
        .i_turn_on_timing_check, .i_irq_pending, .i_cooldown, .i_fault_off, .i_power_good, .i_det_done,
        .i_det_valid, .i_det_changed, .i_cls_done, .i_cls_valid, .i_cls_changed, .i_turn_on_window_ok,
        .o_rdata, .o_irq, .o_wide_access, .o_multi_level_shutdown, .o_priority_reg_a, .o_detect_enable_flag,
        .o_class_enable_flag, .o_start_detection, .o_start_classify, .o_port_power_on,
        .o_power_enabled_status, .o_power_good_status, .o_detection_event_flag, .o_class_event_flag,
        .o_power_enable_change_flag, .o_power_good_change_flag, .o_port_clear);
    ////////////////////////////////////////////////////////////
    // start pulse counters and run limit
    always @(posedge i_clk) begin
        ndet += $countones(o_start_detection);
        ncls += $countones(o_start_classify);
        cyc++;
        if (cyc == 90000) begin
            fails++;
            print_verdict();
        end
    end
    task automatic cmp(input logic [7:0] got, input int exp);
        comparisons++;
        if (got !== exp[7:0]) begin
            fails++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp[7:0]);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge i_clk);
        #1;
    endtask
    task automatic print_verdict;
        if (fails == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        n = $urandom(57);
        repeat (20) @(posedge i_clk);
        i_rst_n <= 1'b1;
        i_host.rd(ADDR_GEN_CFG, r);
        cmp(r, 32'h80);
        cmp(o_priority_reg_a, 32'h15);
        // random configuration writes and read-back
        repeat (4) begin
            n = $urandom;
            i_host.wr(ADDR_GEN_CFG, n[7:0]);
            m_cfg = n & 32'hfc;
            i_host.rd(ADDR_GEN_CFG, r);
            cmp(r, m_cfg);
            cmp(8'({o_wide_access, o_multi_level_shutdown}), (m_cfg >> 4) & 3);
            cmp(o_priority_reg_a, m_cfg[4] ? 32'h27 : 32'h15);
        end
        foreach (ra[j]) begin
            i_host.rd(ra[j], r);
            cmp(r, 0);
        end
        // interrupt gate
        i_host.wr(ADDR_GEN_CFG, 8'h80);
        i_irq_pending <= 1'b1;
        tick(2);
        cmp(8'(o_irq), 1);
        i_host.wr(ADDR_GEN_CFG, 8'h00);
        tick(2);
        cmp(8'(o_irq), 0);
        // random manual power writes
        i_host.wr(ADDR_POWER, 8'hf0);
        m_on = 0;
        repeat (8) begin
            n = $urandom;
            i_host.wr(ADDR_POWER, n[7:0]);
            k = m_on;
            m_on = (m_on | n[3:0]) & ~n[7:4];
            tick(1);
            cmp(8'(o_port_power_on), m_on);
            cmp(8'(o_power_enable_change_flag), k ^ m_on);
        end
        i_host.wr(ADDR_POWER, 8'hf0);
        i_cooldown <= 4'h1;
        i_host.wr(ADDR_POWER, 8'h01);
        tick(1);
        cmp(8'(o_port_power_on), 0);
        i_cooldown <= 4'h0;
        i_mode <= MODE_OFF;
        i_host.wr(ADDR_POWER, 8'h0f);
        tick(1);
        cmp(8'(o_port_power_on), 0);
        i_mode <= MODE_MANUAL;
        // manual restarts, then one held through a cool-down
        ndet = 0;
        ncls = 0;
        i_host.wr(ADDR_RESTART, 8'h21);
        tick(6);
        cmp(8'(ndet), 1);
        cmp(8'(ncls), 1);
        @(posedge i_clk) i_cooldown <= 4'h1;
        ndet = 0;
        i_host.wr(ADDR_RESTART, 8'h01);
        tick(6);
        cmp(8'(ndet), 0);
        @(posedge i_clk) i_cooldown <= 4'h0;
        tick(6);
        cmp(8'(ndet), 1);
        // event flags: every cycle, change-only unchanged, change-only changed
        for (k = 0; k < 3; k++) begin
            i_host.wr(ADDR_GEN_CFG, k > 0 ? 8'h0c : 8'h00);
            i_det_done <= 4'h1;
            i_cls_done <= 4'h1;
            i_det_changed <= {3'h0, k == 2};
            i_cls_changed <= {3'h0, k == 2};
            @(posedge i_clk) i_det_done <= 4'h0;
            i_cls_done <= 4'h0;
            tick(2);
            cmp(8'(o_detection_event_flag[0]), k != 1);
            cmp(8'(o_class_event_flag[0]), k != 1);
            i_host.wr(ADDR_POWER, 8'h01);
            i_host.wr(ADDR_POWER, 8'h10);
            tick(3);
            cmp(8'(o_detection_event_flag[0]), 0);
        end
        // semiauto restart sets enables, turn-off clears them
        i_mode <= MODE_SEMIAUTO;
        i_host.wr(ADDR_RESTART, 8'h11);
        tick(3);
        cmp(8'({o_detect_enable_flag[0], o_class_enable_flag[0]}), 3);
        i_host.wr(ADDR_POWER, 8'h01);
        i_host.wr(ADDR_POWER, 8'h10);
        tick(3);
        cmp(8'({o_detect_enable_flag[0], o_class_enable_flag[0]}), 0);
        i_host.wr(ADDR_POWER, 8'h01);
        tick(1);
        cmp(8'(o_port_power_on[0]), 1);
        // checked turn-on with timing check, then a missed window retry
        i_host.wr(ADDR_POWER, 8'h10);
        i_turn_on_timing_check <= 1'b1;
        i_host.wr(ADDR_RESTART, 8'h01);
        i_det_valid <= 4'h1;
        i_turn_on_window_ok <= 4'h1;
        i_host.wr(ADDR_POWER, 8'h01);
        tick(1);
        cmp(8'(o_port_power_on[0]), 1);
        i_host.wr(ADDR_POWER, 8'h10);
        i_host.wr(ADDR_RESTART, 8'h01);
        ndet = 0;
        tick(4);
        cmp(8'(ndet != 0), 1);
        i_turn_on_window_ok <= 4'h0;
        i_host.wr(ADDR_POWER, 8'h01);
        tick(2);
        cmp(8'(o_port_power_on[0]), 0);
        i_turn_on_window_ok <= 4'h1;
        i_det_done <= 4'h1;
        @(posedge i_clk) i_det_done <= 4'h0;
        tick(2);
        cmp(8'(o_port_power_on[0]), 1);
        print_verdict();
    end
endmodule
bind pse_port_command_registers pse_cmd_monitor i_mon (.i_clk, .i_rst_n, .i_wr_en, .i_rd_en, .i_addr,
    .i_wdata, .i_mode, .i_irq_pending, .i_cooldown, .i_fault_off, .o_rdata, .o_irq, .o_wide_access,
    .o_multi_level_shutdown, .o_port_power_on, .o_power_enable_change_flag);
